// ===== logic/pss_cfg.svh
/*
  offsets, field positions, limits and timing counts of the pll setup
  sequencer; assumes inclusion by bare name from the design files.
*/
`ifndef PSS_CFG_SVH
`define PSS_CFG_SVH
`define PSS_REG_FIN     8'h00
`define PSS_REG_REQ     8'h04
`define PSS_REG_MODE    8'h08
`define PSS_REG_LIMIT   8'h0C
`define PSS_REG_CTRL    8'h10
`define PSS_REG_STATUS  8'h14
`define PSS_REG_RESULT  8'h18
`define PSS_REG_CLOCK   8'h1C
`define PSS_REG_PLLW    8'h20
`define PSS_REG_AHBDIV  8'h24
`define PSS_CTRL_START  0
`define PSS_STAT_BUSY   0
`define PSS_STAT_DONE   1
`define PSS_FIN_MIN     32'h0000_2710
`define PSS_FIN_MAX     32'h0000_61A8
`define PSS_REQ_MIN     32'h0000_0001
`define PSS_REQ_MAX     32'h0000_C350
`define PSS_MAIN_MAX    32'h0000_C350
`define PSS_CCO_MIN     32'h0002_6160
`define PSS_CCO_MAX     32'h0004_E200
`define PSS_MODE_MAX    32'h0000_0003
`define PSS_M_MAX       6'h20
`define PSS_DIV_MAX     9'h0FF
`define PSS_WORD_RST    7'h00
`define PSS_AHB_RST     8'h01
`define PSS_LOCK_US     100
`define PSS_CLK_MHZ     20
`define PSS_LOCK_CYC    (`PSS_LOCK_US * `PSS_CLK_MHZ)
`endif

// ===== logic/pss_pkg.sv
/*
  types of the pll setup sequencer; assumes nothing beyond the compiler.
*/
package pss_pkg;
  typedef enum logic [1:0] {
    match_exact, match_at_most, match_at_least, match_nearest
  } pss_match_e;
  typedef enum logic [2:0] {
    result_ok, result_bad_frequency, result_invalid_mode,
    result_no_solution, result_lock_timeout
  } pss_result_e;
  typedef enum logic [2:0] {
    st_idle, st_check, st_cand, st_quo, st_sys, st_apply, st_lock
  } pss_state_e;
endpackage

// ===== logic/pss_div_if.sv
/*
  link between the sequencer and its serial divider; both run on one clock.
*/
`timescale 1ns/1ps
interface pss_div_if;
  logic        go;
  logic [31:0] num;
  logic [31:0] den;
  logic        done;
  logic [31:0] quot;
  logic [31:0] rem;
  modport master (output go, num, den, input done, quot, rem);
  modport slave  (input go, num, den, output done, quot, rem);
endinterface

// ===== logic/pss_div.sv
/*
  restoring serial divider, one quotient bit per clock, 33 cycles a go;
  assumes a non-zero divisor and no new go while a division runs.
*/
`timescale 1ns/1ps
module pss_div (
  input  wire logic core_clk,
  input  wire logic rst,
  pss_div_if.slave  dv
);
  logic [5:0]  cnt, next_cnt;
  logic [31:0] q, next_q;
  logic [31:0] r, next_r;
  logic [31:0] d, next_d;
  logic        run, next_run;
  logic        fin, next_fin;
  logic [32:0] trial;

  always_comb begin
    next_cnt = cnt;
    next_q   = q;
    next_r   = r;
    next_d   = d;
    next_run = run;
    next_fin = 1'b0;
    trial    = {r, q[31]} - {1'b0, d};
    if (dv.go) begin
      next_q   = dv.num;
      next_d   = dv.den;
      next_r   = 32'h0000_0000;
      next_cnt = 6'h00;
      next_run = 1'b1;
    end else if (run) begin
      if (trial[32]) begin
        next_r = {r[30:0], q[31]};
        next_q = {q[30:0], 1'b0};
      end else begin
        next_r = trial[31:0];
        next_q = {q[30:0], 1'b1};
      end
      next_cnt = cnt + 6'h01;
      if (cnt == 6'h1F) begin
        next_run = 1'b0;
        next_fin = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= 6'h00;
      q   <= 32'h0000_0000;
      r   <= 32'h0000_0000;
      d   <= 32'h0000_0001;
      run <= 1'b0;
      fin <= 1'b0;
    end else begin
      cnt <= next_cnt;
      q   <= next_q;
      r   <= next_r;
      d   <= next_d;
      run <= next_run;
      fin <= next_fin;
    end
  end

  assign dv.done = fin;
  assign dv.quot = q;
  assign dv.rem  = r;
endmodule

// ===== logic/pss_sequencer.sv
/*
  pll setup sequencer: takes a command over the register port, searches
  multiplier, post divider and ahb divider, applies them, waits for lock when the pll is used.
  assumes pll reference selected, main clock on pll input and ahb divider
  at 1 before a command, with interrupts masked until done.
*/
// Implementation choices: the strobed register port and the register addresses.
// Behaviour
// - input frequency valid 10000 to 25000 kHz
// - requested clock valid 1 to 50000 kHz
// - bad frequency: code 1, input returned
// - main clock never above 50 MHz
// - mode codes exact, at-most, at-least, nearest
// - exact solution searched before any relaxation
// - exact mode succeeds only on exact rate
// - nearest mode picks the closest rate
// - at-most never above, at-least never below
// - unknown mode: code 2, pll untouched
// - no solution: code 3, pll untouched
// - bypass pll when division alone suffices
// - write values, switch to pll only if needed
// - success: code 0 plus achieved clock
// - zero poll limit waits forever for lock
// - poll limit exceeded: code 4, settings kept
// - lock expected within 100 microseconds
`timescale 1ns/1ps
`include "pss_cfg.svh"
module pss_sequencer
  import pss_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        pll_locked,
  output logic      [6:0]  pll_control_word,
  output logic             pll_power_on,
  output logic             main_clk_from_pll,
  output logic      [7:0]  ahb_clock_divider,
  output logic             busy,
  output logic             done
);
  pss_div_if dvi ();

  pss_div u_div (
    .core_clk (core_clk),
    .rst      (rst),
    .dv       (dvi.slave)
  );

  pss_state_e  st, next_st;
  logic [31:0] p_fin, next_p_fin;
  logic [31:0] p_req, next_p_req;
  logic [31:0] p_mode, next_p_mode;
  logic [31:0] p_limit, next_p_limit;
  logic [2:0]  res_code, next_res_code;
  logic [31:0] res_clk, next_res_clk;
  logic        done_r, next_done_r;
  logic        done_flag, next_done_flag;
  logic [5:0]  m_idx, next_m_idx;
  logic [8:0]  cur_div, next_cur_div;
  logic        try_hi, next_try_hi;
  logic        b_found, next_b_found;
  logic        b_exact, next_b_exact;
  logic [5:0]  b_m, next_b_m;
  logic [1:0]  b_p, next_b_p;
  logic [7:0]  b_div, next_b_div;
  logic [31:0] b_sys, next_b_sys;
  logic [31:0] b_err, next_b_err;
  logic [6:0]  pw, next_pw;
  logic        pwr, next_pwr;
  logic        msel, next_msel;
  logic [7:0]  ahb, next_ahb;
  logic [6:0]  old_pw, next_old_pw;
  logic        old_pwr, next_old_pwr;
  logic [31:0] polls, next_polls;
  logic        go, next_go;
  logic [31:0] num, next_num;
  logic [31:0] den, next_den;
  logic [31:0] rdata, next_rdata;

  logic [31:0] cand_main;
  logic [3:0]  p_ok;
  logic [1:0]  p_sel;
  logic        cand_ok;
  logic        ex, above, below, allowed, take;
  logic [31:0] err;
  logic [31:0] qclip;
  pss_match_e  mode;

  assign mode = pss_match_e'(p_mode[1:0]);
  assign cand_main = (m_idx == 6'h00) ? p_fin :
                     32'(p_fin * {26'h0, m_idx});

  // cco window checked for each post divider 2, 4, 8, 16
  for (genvar g = 0; g < 4; g++) begin : g_post
    logic [31:0] cco;
    assign cco     = cand_main << (g + 1);
    assign p_ok[g] = (cco >= `PSS_CCO_MIN) && (cco <= `PSS_CCO_MAX);
  end

  always_comb begin
    p_sel = 2'h0;
    if (p_ok[0])
      p_sel = 2'h0;
    else if (p_ok[1])
      p_sel = 2'h1;
    else if (p_ok[2])
      p_sel = 2'h2;
    else
      p_sel = 2'h3;
  end

  // bypass needs no cco window; pll paths must keep main clock in range
  assign cand_ok = (m_idx == 6'h00) ||
                   ((cand_main <= `PSS_MAIN_MAX) && (|p_ok));

  // quality of the division just finished
  assign ex    = (dvi.rem == 32'h0) && (dvi.quot == p_req);
  assign above = (dvi.quot > p_req) ||
                 ((dvi.quot == p_req) && (dvi.rem != 32'h0));
  assign below = dvi.quot < p_req;
  assign err   = above ? dvi.quot - p_req : p_req - dvi.quot;
  always_comb begin
    unique case (mode)
      match_exact:    allowed = ex;
      match_at_most:  allowed = ex || !above;
      match_at_least: allowed = ex || !below;
      match_nearest:  allowed = 1'b1;
    endcase
  end
  // exact beats everything; ties keep the earlier, bypass first
  assign take = allowed && (!b_found || (ex && !b_exact) ||
                (!b_exact && !ex && err < b_err));
  assign qclip = (dvi.quot == 32'h0) ? 32'h1 :
                 (dvi.quot > 32'(`PSS_DIV_MAX)) ? 32'(`PSS_DIV_MAX) :
                 dvi.quot;

  always_comb begin
    next_st        = st;
    next_p_fin     = p_fin;
    next_p_req     = p_req;
    next_p_mode    = p_mode;
    next_p_limit   = p_limit;
    next_res_code  = res_code;
    next_res_clk   = res_clk;
    next_done_r    = 1'b0;
    next_done_flag = done_flag;
    next_m_idx     = m_idx;
    next_cur_div   = cur_div;
    next_try_hi    = try_hi;
    next_b_found   = b_found;
    next_b_exact   = b_exact;
    next_b_m       = b_m;
    next_b_p       = b_p;
    next_b_div     = b_div;
    next_b_sys     = b_sys;
    next_b_err     = b_err;
    next_pw        = pw;
    next_pwr       = pwr;
    next_msel      = msel;
    next_ahb       = ahb;
    next_old_pw    = old_pw;
    next_old_pwr   = old_pwr;
    next_polls     = polls;
    next_go        = 1'b0;
    next_num       = num;
    next_den       = den;
    next_rdata     = 32'h0000_0000;

    // register port; parameters frozen while a command runs
    if (reg_wr && st == st_idle) begin
      unique case (reg_addr)
        `PSS_REG_FIN:   next_p_fin   = reg_wdata;
        `PSS_REG_REQ:   next_p_req   = reg_wdata;
        `PSS_REG_MODE:  next_p_mode  = reg_wdata;
        `PSS_REG_LIMIT: next_p_limit = reg_wdata;
        `PSS_REG_CTRL: begin
          if (reg_wdata[`PSS_CTRL_START])
            next_st = st_check;
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `PSS_REG_FIN:    next_rdata = p_fin;
        `PSS_REG_REQ:    next_rdata = p_req;
        `PSS_REG_MODE:   next_rdata = p_mode;
        `PSS_REG_LIMIT:  next_rdata = p_limit;
        `PSS_REG_STATUS: begin
          next_rdata[`PSS_STAT_BUSY] = (st != st_idle);
          next_rdata[`PSS_STAT_DONE] = done_flag;
          next_done_flag = 1'b0;
        end
        `PSS_REG_RESULT: next_rdata = {29'h0, res_code};
        `PSS_REG_CLOCK:  next_rdata = res_clk;
        `PSS_REG_PLLW:   next_rdata = {25'h0, pw};
        `PSS_REG_AHBDIV: next_rdata = {24'h0, ahb};
        default:         next_rdata = 32'h0000_0000;
      endcase
    end

    unique case (st)
      st_idle: ;
      st_check: begin
        next_res_clk = p_fin;
        if (p_fin < `PSS_FIN_MIN || p_fin > `PSS_FIN_MAX ||
            p_req < `PSS_REQ_MIN || p_req > `PSS_REQ_MAX) begin
          next_res_code = result_bad_frequency;
          next_st       = st_idle;
          next_done_r   = 1'b1;
        end else if (p_mode > `PSS_MODE_MAX) begin
          next_res_code = result_invalid_mode;
          next_st       = st_idle;
          next_done_r   = 1'b1;
        end else begin
          next_m_idx   = 6'h00;
          next_b_found = 1'b0;
          next_b_exact = 1'b0;
          next_st      = st_cand;
        end
      end
      st_cand: begin
        if (m_idx > `PSS_M_MAX) begin
          if (b_found) begin
            next_st = st_apply;
          end else begin
            next_res_code = result_no_solution;
            next_st       = st_idle;
            next_done_r   = 1'b1;
          end
        end else if (!cand_ok) begin
          next_m_idx = m_idx + 6'h01;
        end else begin
          next_num = cand_main;
          next_den = p_req;
          next_go  = 1'b1;
          next_st  = st_quo;
        end
      end
      st_quo: if (dvi.done) begin
        // floor and floor+1 bracket the request for this main clock
        next_cur_div = qclip[8:0];
        next_try_hi  = 1'b0;
        next_den     = qclip;
        next_go      = 1'b1;
        next_st      = st_sys;
      end
      st_sys: if (dvi.done) begin
        if (take) begin
          next_b_found = 1'b1;
          next_b_exact = ex;
          next_b_m     = m_idx;
          next_b_p     = p_sel;
          next_b_div   = cur_div[7:0];
          next_b_sys   = dvi.quot;
          next_b_err   = err;
        end
        if (!try_hi && cur_div < `PSS_DIV_MAX) begin
          next_cur_div = cur_div + 9'h001;
          next_try_hi  = 1'b1;
          next_den     = {23'h0, cur_div + 9'h001};
          next_go      = 1'b1;
        end else begin
          next_m_idx = m_idx + 6'h01;
          next_st    = st_cand;
        end
      end
      st_apply: begin
        next_old_pw  = pw;
        next_old_pwr = pwr;
        next_polls   = 32'h0000_0000;
        if (b_m == 6'h00) begin
          next_ahb      = b_div;
          next_msel     = 1'b0;
          next_res_code = result_ok;
          next_res_clk  = b_sys;
          next_st       = st_idle;
          next_done_r   = 1'b1;
        end else begin
          next_pw  = {b_p, 5'(b_m - 6'h01)};
          next_pwr = 1'b1;
          next_st  = st_lock;
        end
      end
      st_lock: begin
        if (pll_locked) begin
          // divider set only as main clock moves here; only bypass sets it on the input
          next_ahb      = b_div;
          next_msel     = 1'b1;
          next_res_code = result_ok;
          next_res_clk  = b_sys;
          next_st       = st_idle;
          next_done_r   = 1'b1;
        end else begin
          next_polls = polls + 32'h1;
          if (p_limit != 32'h0 && polls + 32'h1 >= p_limit) begin
            next_pw       = old_pw;
            next_pwr      = old_pwr;
            next_res_code = result_lock_timeout;
            next_res_clk  = p_fin;
            next_st       = st_idle;
            next_done_r   = 1'b1;
          end
        end
      end
    endcase
    if (done_r)
      next_done_flag = 1'b1; // set wins over read clear
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st        <= st_idle;
      p_fin     <= 32'h0000_0000;
      p_req     <= 32'h0000_0000;
      p_mode    <= 32'h0000_0000;
      p_limit   <= 32'h0000_0000;
      res_code  <= 3'h0;
      res_clk   <= 32'h0000_0000;
      done_r    <= 1'b0;
      done_flag <= 1'b0;
      m_idx     <= 6'h00;
      cur_div   <= 9'h001;
      try_hi    <= 1'b0;
      b_found   <= 1'b0;
      b_exact   <= 1'b0;
      b_m       <= 6'h00;
      b_p       <= 2'h0;
      b_div     <= 8'h01;
      b_sys     <= 32'h0000_0000;
      b_err     <= 32'h0000_0000;
      pw        <= `PSS_WORD_RST;
      pwr       <= 1'b0;
      msel      <= 1'b0;
      ahb       <= `PSS_AHB_RST;
      old_pw    <= `PSS_WORD_RST;
      old_pwr   <= 1'b0;
      polls     <= 32'h0000_0000;
      go        <= 1'b0;
      num       <= 32'h0000_0000;
      den       <= 32'h0000_0001;
      rdata     <= 32'h0000_0000;
    end else begin
      st        <= next_st;
      p_fin     <= next_p_fin;
      p_req     <= next_p_req;
      p_mode    <= next_p_mode;
      p_limit   <= next_p_limit;
      res_code  <= next_res_code;
      res_clk   <= next_res_clk;
      done_r    <= next_done_r;
      done_flag <= next_done_flag;
      m_idx     <= next_m_idx;
      cur_div   <= next_cur_div;
      try_hi    <= next_try_hi;
      b_found   <= next_b_found;
      b_exact   <= next_b_exact;
      b_m       <= next_b_m;
      b_p       <= next_b_p;
      b_div     <= next_b_div;
      b_sys     <= next_b_sys;
      b_err     <= next_b_err;
      pw        <= next_pw;
      pwr       <= next_pwr;
      msel      <= next_msel;
      ahb       <= next_ahb;
      old_pw    <= next_old_pw;
      old_pwr   <= next_old_pwr;
      polls     <= next_polls;
      go        <= next_go;
      num       <= next_num;
      den       <= next_den;
      rdata     <= next_rdata;
    end
  end

  assign dvi.go  = go;
  assign dvi.num = num;
  assign dvi.den = den;

  assign reg_rdata         = rdata;
  assign pll_control_word  = pw;
  assign pll_power_on      = pwr;
  assign main_clk_from_pll = msel;
  assign ahb_clock_divider = ahb;
  assign busy              = (st != st_idle);
  assign done              = done_r;
endmodule

// ===== tb/pss_sequencer_monitor.sv
/*
  checker for the pll setup sequencer top ports.
  assumes one clock, rst async active high, bound by the line at the foot.
*/
`timescale 1ns/1ps
`include "pss_cfg.svh"
module pss_seq_monitor (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        pll_locked,
  input wire logic [6:0]  pll_control_word,
  input wire logic        pll_power_on,
  input wire logic        main_clk_from_pll,
  input wire logic [7:0]  ahb_clock_divider,
  input wire logic        busy,
  input wire logic        done
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // poll limit as the sequencer took it; writes while busy are ignored
  logic [31:0] lim;
  logic [31:0] next_lim;
  always_comb begin
    next_lim = lim;
    if (reg_wr && reg_addr == `PSS_REG_LIMIT && !busy)
      next_lim = reg_wdata;
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      lim <= 32'h0;
    else
      lim <= next_lim;
  end
  // lock wait seen from the ports: word or power moved inside a command
  logic       wait_q, next_wait;
  logic [6:0] word_q;
  logic       pwr_q;
  always_comb begin
    next_wait = wait_q;
    if (done)
      next_wait = 1'b0;
    else if (busy && (pll_control_word != word_q
             || (pll_power_on && !pwr_q)))
      next_wait = 1'b1;
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wait_q <= 1'b0;
      word_q <= 7'h00;
      pwr_q  <= 1'b0;
    end else begin
      wait_q <= next_wait;
      word_q <= pll_control_word;
      pwr_q  <= pll_power_on;
    end
  end
  chk_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  chk_done_idle: assert property (done |-> !busy)
    else $error("busy high with done");
  chk_start_busy: assert property (
    reg_wr && reg_addr == `PSS_REG_CTRL && reg_wdata[0] && !busy |=> busy)
    else $error("start not followed by busy");
  chk_busy_end: assert property ($fell(busy) |-> done)
    else $error("busy fell without done");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data without read");
  chk_status_busy: assert property (
    reg_rd && reg_addr == `PSS_REG_STATUS |=> reg_rdata[0] == $past(busy))
    else $error("status busy bit wrong");
  chk_word_busy: assert property (
    $changed(pll_control_word) |-> $past(busy))
    else $error("pll word changed outside a command");
  chk_ahb_done: assert property ($changed(ahb_clock_divider) |-> done)
    else $error("ahb divider changed outside completion");
  chk_switch_lock: assert property (
    $rose(main_clk_from_pll) |-> done && pll_power_on && $past(pll_locked))
    else $error("switched to pll without lock");
  chk_zero_wait: assert property (
    busy && pll_power_on && wait_q && lim == 32'h0 && !pll_locked
    |=> !done)
    else $error("finished without lock under zero limit");
endmodule
bind pss_sequencer pss_seq_monitor mon_u (
  .core_clk          (core_clk),
  .rst               (rst),
  .reg_addr          (reg_addr),
  .reg_wdata         (reg_wdata),
  .reg_wr            (reg_wr),
  .reg_rd            (reg_rd),
  .reg_rdata         (reg_rdata),
  .pll_locked        (pll_locked),
  .pll_control_word  (pll_control_word),
  .pll_power_on      (pll_power_on),
  .main_clk_from_pll (main_clk_from_pll),
  .ahb_clock_divider (ahb_clock_divider),
  .busy              (busy),
  .done              (done)
);

// ===== tb/pss_pll_model.sv
/*
  behavioural pll: locks lock_delay cycles after power-on or retune.
  assumes the sequencer drives power and word; 16'hFFFF means never locks.
*/
`timescale 1ns/1ps
module pss_pll_model (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       pll_power_on,
  input  wire logic [6:0] pll_control_word,
  input  wire logic [15:0] lock_delay,
  output logic            pll_locked
);
  logic [15:0] cnt;
  logic [6:0]  word_seen;
  logic        lock_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= 16'h0;
      word_seen <= 7'h00;
      lock_q <= 1'b0;
    end else begin
      word_seen <= pll_control_word;
      // retuning loses lock, as a real loop would
      if (!pll_power_on || pll_control_word != word_seen)
        cnt <= 16'h0;
      else if (cnt != 16'hFFFF)
        cnt <= cnt + 16'h1;
      lock_q <= pll_power_on && lock_delay != 16'hFFFF
        && cnt >= lock_delay && pll_control_word == word_seen;
    end
  end
  // a retune drops lock at once; a stale high would end the wait early
  assign pll_locked = lock_q && pll_power_on
    && pll_control_word == word_seen;
endmodule

// ===== tb/pss_sequencer_bench.sv
/*
  self-checking bench of the pll setup sequencer over its register port.
  assumes the design files, the checker and the pll model are compiled first.
*/
`timescale 1ns/1ps
`include "pss_cfg.svh"
module pss_sequencer_bench
  import pss_pkg::*;
;
  logic        core_clk, rst, reg_wr, reg_rd, pll_locked;
  logic [7:0]  reg_addr, ahb_clock_divider;
  logic [31:0] reg_wdata, reg_rdata, rd_val;
  logic [6:0]  pll_control_word;
  logic        pll_power_on, main_clk_from_pll, busy, done;
  logic [15:0] lock_delay;
  int          miscompares, total_checks, cycles;
  logic [31:0] bad_fin [4] = '{32'd9999, 32'd25001, 32'd12000, 32'd12000};
  logic [31:0] bad_req [4] = '{32'd1000, 32'd1000, 32'd0, 32'd50001};

  pss_sequencer dut_u (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pll_locked(pll_locked),
    .pll_control_word(pll_control_word), .pll_power_on(pll_power_on),
    .main_clk_from_pll(main_clk_from_pll),
    .ahb_clock_divider(ahb_clock_divider), .busy(busy), .done(done));
  pss_pll_model pll_u (.core_clk(core_clk), .rst(rst),
    .pll_power_on(pll_power_on), .pll_control_word(pll_control_word),
    .lock_delay(lock_delay), .pll_locked(pll_locked));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // a hang in the lock wait must not stall the run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 80000) begin
      miscompares++;
      $display("ERROR at %0t: run limit reached", $time);
      conclude();
    end
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_code(input logic [31:0] got, input pss_result_e exp);
    total_checks++;
    if (got !== 32'(exp)) begin
      miscompares++;
      $display("ERROR at %0t: code %h expected %0d", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask

  task automatic start_cmd(input logic [31:0] f, r, m, l);
    wr(`PSS_REG_FIN, f);
    wr(`PSS_REG_REQ, r);
    wr(`PSS_REG_MODE, m);
    wr(`PSS_REG_LIMIT, l);
    wr(`PSS_REG_CTRL, 32'h1);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 6000) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 6000) begin
      miscompares++;
      $display("ERROR at %0t: no done", $time);
    end
  endtask
  task automatic expect_res(input pss_result_e c, input logic [31:0] k);
    rd(`PSS_REG_RESULT, rd_val);
    chk_code(rd_val, c);
    rd(`PSS_REG_CLOCK, rd_val);
    chk_word(rd_val, k);
  endtask
  task automatic cmd(input logic [31:0] f, r, m, l, input pss_result_e c,
                     input logic [31:0] k);
    start_cmd(f, r, m, l);
    wait_done();
    expect_res(c, k);
  endtask
  task automatic pll_state(input logic [6:0] w, input logic p, input logic s,
                           input logic [7:0] a);
    chk_word(32'(pll_control_word), 32'(w));
    chk_word({30'h0, pll_power_on, main_clk_from_pll}, {30'h0, p, s});
    chk_word(32'(ahb_clock_divider), 32'(a));
  endtask

  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    lock_delay = 16'h0028;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    pll_state(7'h00, 1'b0, 1'b0, 8'h01);
    rd(8'h30, rd_val);
    chk_word(rd_val, 32'h0);
    $display("test reset done");
    // bad frequency wins over a bad mode
    for (int i = 0; i < 4; i++)
      cmd(bad_fin[i], bad_req[i], 32'h4, 32'h0, result_bad_frequency, bad_fin[i]);
    cmd(32'd12000, 32'd25000, 32'h4, 32'h0, result_invalid_mode, 32'd12000);
    cmd(32'd12000, 32'd25000, 32'hFF, 32'h0, result_invalid_mode, 32'd12000);
    pll_state(7'h00, 1'b0, 1'b0, 8'h01);
    $display("test refusals done");
    cmd(32'd10000, 32'd10000, 32'h0, 32'h0, result_ok, 32'd10000);
    cmd(32'd25000, 32'd5000, 32'h0, 32'h0, result_ok, 32'd5000);
    pll_state(7'h00, 1'b0, 1'b0, 8'h05);
    cmd(32'd10000, 32'd1, 32'h1, 32'h0, result_no_solution, 32'd10000);
    $display("test bypass done");
    lock_delay <= 16'hFFFF;
    cmd(32'd12000, 32'd25000, 32'h1, 32'h5, result_lock_timeout, 32'd12000);
    pll_state(7'h00, 1'b0, 1'b0, 8'h05);
    $display("test lock timeout done");
    // retry after a timeout, zero limit, a refused write while busy
    // worst-case lock time, waited out under a zero limit
    lock_delay <= 16'(`PSS_LOCK_CYC);
    start_cmd(32'd12000, 32'd25000, 32'h1, 32'h0);
    wr(`PSS_REG_FIN, 32'd9999);
    wait_done();
    expect_res(result_ok, 32'd24000);
    pll_state(7'h41, 1'b1, 1'b1, 8'h01);
    rd(`PSS_REG_FIN, rd_val);
    chk_word(rd_val, 32'd12000);
    rd(`PSS_REG_STATUS, rd_val);
    chk_word(rd_val, 32'h2);
    rd(`PSS_REG_STATUS, rd_val);
    chk_word(rd_val, 32'h0);
    $display("test pll at most done");
    lock_delay <= 16'd40;
    cmd(32'd12000, 32'd25000, 32'h2, 32'd2400, result_ok, 32'd36000);
    chk_word(32'(pll_control_word), 32'h42);
    cmd(32'd12000, 32'd25000, 32'h3, 32'd2400, result_ok, 32'd24000);
    cmd(32'd12000, 32'd25000, 32'h0, 32'h0, result_no_solution, 32'd12000);
    pll_state(7'h41, 1'b1, 1'b1, 8'h01);
    cmd(32'd25000, 32'd50000, 32'h3, 32'd2400, result_ok, 32'd50000);
    pll_state(7'h21, 1'b1, 1'b1, 8'h01);
    rd(`PSS_REG_PLLW, rd_val);
    chk_word(rd_val, 32'h21);
    rd(`PSS_REG_AHBDIV, rd_val);
    chk_word(rd_val, 32'h1);
    $display("test modes done");
    conclude();
  end
endmodule
